// ---- hw/tmr_defs.vh ----
/*
  Constants of the three-channel interval timer: port offsets, control word
  fields, read/load codes, counting modes and reset values.
  Assumes inclusion by bare name from the timer design file.
*/
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH

// byte-wide i/o port offsets, bit 0 ignored (pairs such as 00D0/00D1)
`define TMR_ADDR_W 8
`define TMR_PORT_CNT0 8'hD0
`define TMR_PORT_CNT1 8'hD2
`define TMR_PORT_CNT2 8'hD4
`define TMR_PORT_CTRL 8'hD6

// control word fields
`define TMR_SEL_HI 7
`define TMR_SEL_LO 6
`define TMR_RWM_HI 5
`define TMR_RWM_LO 4
`define TMR_MODE_HI 3
`define TMR_MODE_LO 1
`define TMR_BCD_BIT 0

// read/load field codes
`define TMR_RWM_LATCH 2'h0
`define TMR_RWM_LSB 2'h1
`define TMR_RWM_MSB 2'h2
`define TMR_RWM_BOTH 2'h3

// counting modes (codes 6 and 7 act as 2 and 3)
`define TMR_MODE0 3'h0
`define TMR_MODE1 3'h1
`define TMR_MODE2 3'h2
`define TMR_MODE3 3'h3
`define TMR_MODE4 3'h4
`define TMR_MODE5 3'h5

// misc values
`define TMR_CNT_ONE 16'h0001
`define TMR_BYTE_ZERO 8'h00
`define TMR_RD_NONE 8'hFF
`define TMR_DIGIT_NINE 4'h9
`define TMR_DIGIT_ZERO 4'h0
`define TMR_DIGIT_ONE 4'h1
// gate pins idle at the pulled-up level
`define TMR_GATE_IDLE 3'h7

`endif

// ---- hw/tmr_timer.v ----
/*
  Three independent 16-bit down-counters behind a byte-wide i/o port bus,
  with one write-only control port and one data port per counter.
  Assumes io strobes come from logic on ref_clk; timer clock and gate pins
  are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`include "tmr_defs.vh"

////////////////////////////////////////////////////////////////////////////
// three-flop synchroniser with agreement filter and rising-edge pulse
// resets to the idle level so no false edge follows reset
module tmr_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire ref_clk,
  input wire resetn,
  input wire [W-1:0] pin,
  output reg [W-1:0] level_reg,
  output wire [W-1:0] rise
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  wire [W-1:0] agree;
  assign agree = ~(s2_reg ^ s3_reg);
  assign rise = agree & s2_reg & ~level_reg;
  // level follows once second and third stages agree
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      level_reg <= INIT;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= (agree & s2_reg) | (~agree & level_reg);
    end
  end
endmodule // tmr_sync

////////////////////////////////////////////////////////////////////////////
// one counter channel
module tmr_channel (
  input wire ref_clk,
  input wire resetn,
  input wire tick,
  input wire gate,
  input wire gate_rise,
  input wire ctl_wr,
  input wire [7:0] ctl_byte,
  input wire data_wr,
  input wire data_rd,
  input wire [7:0] wdata,
  output wire [7:0] rd_byte,
  output reg out_reg
);
  reg [2:0] mode_reg;
  reg [1:0] rwm_reg;
  reg bcd_reg;
  reg [15:0] init_reg;
  reg [15:0] cnt_reg;
  reg [15:0] latch_reg;
  reg latched_reg;
  reg wr_hi_reg;
  reg rd_hi_reg;
  reg load_pend_reg;
  reg trig_pend_reg;
  reg run_reg;
  wire [15:0] cnt_dec;
  wire [15:0] view;
  wire [2:0] m;
  wire term;
  wire last_rd;

  // bcd-aware decrement by one, 0 wraps to the top count
  function [15:0] dec16;
    input [15:0] v;
    input bcd;
    integer i;
    reg borrow;
    reg [3:0] d;
    begin
      dec16 = v - `TMR_CNT_ONE;
      borrow = 1'b1;
      if (bcd) begin
        for (i = 0; i < 4; i = i + 1) begin
          d = v[i*4 +: 4];
          if (borrow && d == `TMR_DIGIT_ZERO) begin
            dec16[i*4 +: 4] = `TMR_DIGIT_NINE;
          end else if (borrow) begin
            dec16[i*4 +: 4] = d - `TMR_DIGIT_ONE;
            borrow = 1'b0;
          end else begin
            dec16[i*4 +: 4] = d;
          end
        end
      end
    end
  endfunction

  assign cnt_dec = dec16(cnt_reg, bcd_reg);
  // codes 6 and 7 fold onto modes 2 and 3
  assign m = (mode_reg[2] && mode_reg[1]) ? {1'b0, mode_reg[1:0]} :
             mode_reg;
  assign term = (cnt_reg == `TMR_CNT_ONE);
  assign view = latched_reg ? latch_reg : cnt_reg;
  // low byte first for two-byte access, else the selected byte
  assign rd_byte = ((rwm_reg == `TMR_RWM_MSB) ||
                    (rwm_reg == `TMR_RWM_BOTH && rd_hi_reg)) ?
                   view[15:8] : view[7:0];
  assign last_rd = (rwm_reg != `TMR_RWM_BOTH) || rd_hi_reg;

  // host side: mode words, count loads, latch and read pointers
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= `TMR_MODE0;
      rwm_reg <= `TMR_RWM_BOTH;
      bcd_reg <= 1'b0;
      latched_reg <= 1'b0;
      latch_reg <= 16'h0000;
      wr_hi_reg <= 1'b0;
      rd_hi_reg <= 1'b0;
    end else if (ctl_wr) begin
      if (ctl_byte[`TMR_RWM_HI:`TMR_RWM_LO] == `TMR_RWM_LATCH) begin
        if (!latched_reg) begin
          latch_reg <= cnt_reg;
          latched_reg <= 1'b1;
          rd_hi_reg <= 1'b0;
        end
      end else begin
        mode_reg <= ctl_byte[`TMR_MODE_HI:`TMR_MODE_LO];
        rwm_reg <= ctl_byte[`TMR_RWM_HI:`TMR_RWM_LO];
        bcd_reg <= ctl_byte[`TMR_BCD_BIT];
        latched_reg <= 1'b0;
        wr_hi_reg <= 1'b0;
        rd_hi_reg <= 1'b0;
      end
    end else begin
      if (data_wr && rwm_reg == `TMR_RWM_BOTH) begin
        wr_hi_reg <= ~wr_hi_reg;
      end
      if (data_rd) begin
        rd_hi_reg <= (rwm_reg == `TMR_RWM_BOTH) ? ~rd_hi_reg : 1'b0;
        if (last_rd) begin
          latched_reg <= 1'b0;
        end
      end
    end
  end

  // initial count register, not touched by reset
  always @(posedge ref_clk) begin
    if (data_wr && !ctl_wr) begin
      case (rwm_reg)
        `TMR_RWM_LSB: init_reg <= {`TMR_BYTE_ZERO, wdata};
        `TMR_RWM_MSB: init_reg <= {wdata, `TMR_BYTE_ZERO};
        default: begin
          if (wr_hi_reg) begin
            init_reg[15:8] <= wdata;
          end else begin
            init_reg[7:0] <= wdata;
          end
        end
      endcase
    end
  end

  // working count register, not touched by reset
  always @(posedge ref_clk) begin
    if (tick) begin
      if (load_pend_reg && !(run_reg &&
          (m == `TMR_MODE2 || m == `TMR_MODE3 ||
           m == `TMR_MODE1 || m == `TMR_MODE5))) begin
        cnt_reg <= init_reg;
      end else if (trig_pend_reg &&
                   (m == `TMR_MODE1 || m == `TMR_MODE5)) begin
        cnt_reg <= init_reg;
      end else if (trig_pend_reg &&
                   (m == `TMR_MODE2 || m == `TMR_MODE3)) begin
        cnt_reg <= init_reg;
      end else if (run_reg && term &&
                   (m == `TMR_MODE2 || m == `TMR_MODE3)) begin
        cnt_reg <= init_reg;
      end else if ((run_reg || m == `TMR_MODE0) &&
                   (gate || m == `TMR_MODE1 || m == `TMR_MODE5)) begin
        cnt_reg <= cnt_dec;
      end
    end
  end

  // sequencing: pending load and trigger, run flag and output
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      load_pend_reg <= 1'b0;
      trig_pend_reg <= 1'b0;
      run_reg <= 1'b0;
      out_reg <= 1'b1;
    end else if (ctl_wr &&
                 ctl_byte[`TMR_RWM_HI:`TMR_RWM_LO] != `TMR_RWM_LATCH) begin
      // new mode word: idle, output high except mode 0
      load_pend_reg <= 1'b0;
      trig_pend_reg <= 1'b0;
      run_reg <= 1'b0;
      out_reg <= (ctl_byte[`TMR_MODE_HI:`TMR_MODE_LO] != `TMR_MODE0);
    end else begin
      // last byte of a load arms the counter; set wins over the tick
      if (data_wr && (rwm_reg != `TMR_RWM_BOTH || wr_hi_reg)) begin
        load_pend_reg <= 1'b1;
      end else if (tick) begin
        load_pend_reg <= 1'b0;
      end
      if (gate_rise) begin
        trig_pend_reg <= 1'b1;
      end else if (tick) begin
        trig_pend_reg <= 1'b0;
      end
      if ((m == `TMR_MODE2 || m == `TMR_MODE3) && !gate) begin
        out_reg <= 1'b1;
      end else if (tick) begin
        case (m)
          `TMR_MODE0: begin
            if (load_pend_reg) begin
              out_reg <= 1'b0;
            end else if (gate && term) begin
              out_reg <= 1'b1;
            end
          end
          `TMR_MODE1: begin
            if (trig_pend_reg) begin
              run_reg <= 1'b1;
              out_reg <= 1'b0;
            end else if (run_reg && term) begin
              run_reg <= 1'b0;
              out_reg <= 1'b1;
            end
          end
          `TMR_MODE2, `TMR_MODE3: begin
            if (load_pend_reg && !run_reg) begin
              run_reg <= 1'b1;
              out_reg <= 1'b1;
            end else if (trig_pend_reg || !run_reg) begin
              out_reg <= 1'b1;
            end else if (m == `TMR_MODE2) begin
              out_reg <= ~term;
            end else if (term) begin
              out_reg <= 1'b1;
            end else if (cnt_reg == ({1'b0, init_reg[15:1]} +
                                     `TMR_CNT_ONE)) begin
              out_reg <= 1'b0;
            end
          end
          `TMR_MODE4: begin
            out_reg <= 1'b1;
            if (load_pend_reg) begin
              run_reg <= 1'b1;
            end else if (run_reg && gate && term) begin
              run_reg <= 1'b0;
              out_reg <= 1'b0;
            end
          end
          `TMR_MODE5: begin
            out_reg <= 1'b1;
            if (trig_pend_reg) begin
              run_reg <= 1'b1;
            end else if (run_reg && term) begin
              run_reg <= 1'b0;
              out_reg <= 1'b0;
            end
          end
          default: out_reg <= 1'b1;
        endcase
      end
    end
  end
endmodule // tmr_channel

////////////////////////////////////////////////////////////////////////////
// top: port decode, gate selection and the three channels
module tmr_timer (
  input wire ref_clk,
  input wire resetn,
  input wire [7:0] io_addr,
  input wire [7:0] io_wdata,
  input wire io_wr,
  input wire io_rd,
  output reg [7:0] io_rdata,
  input wire timer_clk,
  input wire [2:0] gate_pin,
  input wire gate_from_ppc,
  input wire [2:0] parallel_port_c,
  output wire [2:0] timer_out
);
  wire tick;
  wire [2:0] gate_src;
  wire [2:0] gate_lvl;
  wire [2:0] gate_rise;
  wire [2:0] sel_ch;
  wire ctl_wr;
  wire [7:0] rd_byte [0:2];
  wire [1:0] ctl_sel;
  genvar g;

  // gate source: pulled-up pin or parallel port output bits
  assign gate_src = gate_from_ppc ? parallel_port_c : gate_pin;

  tmr_sync #(.W(1)) u_clk_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin(timer_clk),
    .level_reg(),
    .rise(tick)
  );

  tmr_sync #(.W(3), .INIT(`TMR_GATE_IDLE)) u_gate_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin(gate_src),
    .level_reg(gate_lvl),
    .rise(gate_rise)
  );

  // port decode, bit 0 of the address ignored
  assign sel_ch[0] = ({io_addr[7:1], 1'b0} == `TMR_PORT_CNT0);
  assign sel_ch[1] = ({io_addr[7:1], 1'b0} == `TMR_PORT_CNT1);
  assign sel_ch[2] = ({io_addr[7:1], 1'b0} == `TMR_PORT_CNT2);
  assign ctl_wr = io_wr && ({io_addr[7:1], 1'b0} == `TMR_PORT_CTRL);
  assign ctl_sel = io_wdata[`TMR_SEL_HI:`TMR_SEL_LO];

  generate
    for (g = 0; g < 3; g = g + 1) begin : ch
      tmr_channel u_ch (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .tick(tick),
        .gate(gate_lvl[g]),
        .gate_rise(gate_rise[g]),
        .ctl_wr(ctl_wr && ctl_sel == g),
        .ctl_byte(io_wdata),
        .data_wr(io_wr && sel_ch[g]),
        .data_rd(io_rd && sel_ch[g]),
        .wdata(io_wdata),
        .rd_byte(rd_byte[g]),
        .out_reg(timer_out[g])
      );
    end
  endgenerate

  // read data register; control port and others read all ones
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      io_rdata <= `TMR_RD_NONE;
    end else if (io_rd) begin
      if (sel_ch[0]) begin
        io_rdata <= rd_byte[0];
      end else if (sel_ch[1]) begin
        io_rdata <= rd_byte[1];
      end else if (sel_ch[2]) begin
        io_rdata <= rd_byte[2];
      end else begin
        io_rdata <= `TMR_RD_NONE;
      end
    end
  end
endmodule // tmr_timer

// ---- testbench/tmr_timer_properties.sv ----
/* checker: port properties of the interval timer
   assumes: bound to tmr_timer, one clock domain */
`timescale 1ns/1ps
module tmr_timer_props (
  input logic ref_clk,
  input logic resetn,
  input logic [7:0] io_addr,
  input logic [7:0] io_wdata,
  input logic io_wr,
  input logic io_rd,
  input logic [7:0] io_rdata,
  input logic timer_clk,
  input logic [2:0] gate_pin,
  input logic gate_from_ppc,
  input logic [2:0] parallel_port_c,
  input logic [2:0] timer_out
);
  logic [2:0] mode0_reg;
  logic [2:0] mode2_reg;
  // mode words seen on the control port
  wire ctl = io_wr && io_addr[7:1] == 7'h6B && io_wdata[5:4] != 2'h0;
  wire ctl0 = ctl && io_wdata[7:6] == 2'h0;
  wire g0 = gate_from_ppc ? parallel_port_c[0] : gate_pin[0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // shadow of the programmed modes
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode0_reg <= 3'h0;
      mode2_reg <= 3'h0;
    end else if (ctl && io_wdata[7:6] == 2'h0) begin
      mode0_reg <= io_wdata[3:1];
    end else if (ctl && io_wdata[7:6] == 2'h2) begin
      mode2_reg <= io_wdata[3:1];
    end
  end
  chk_rdata_holds: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read byte changed without a read");
  chk_ctrl_unread: assert property (
    io_rd && io_addr[7:1] == 7'h6B |=> io_rdata == 8'hFF)
    else $error("control port read not FF");
  chk_unmapped_ff: assert property (
    io_rd && io_addr[7:3] != 5'h1A |=> io_rdata == 8'hFF)
    else $error("unmapped read not FF");
  chk_mode_out_high: assert property (
    ctl0 && io_wdata[3:1] != 3'h0 |=> timer_out[0])
    else $error("mode word did not set output high");
  chk_mode0_out_low: assert property (
    ctl0 && io_wdata[3:1] == 3'h0 |=> !timer_out[0])
    else $error("mode 0 word did not set output low");
  chk_gate_forces_high: assert property (
    (mode0_reg[1] && !g0) [*8] |-> timer_out[0])
    else $error("low gate left output low");
  chk_rate_pulse_width: assert property (
    $fell(timer_out[0]) && mode0_reg == 3'h2 && g0
    |-> ##[110:135] timer_out[0])
    else $error("rate pulse width wrong");
  chk_strobe_width: assert property (
    $fell(timer_out[2]) && mode2_reg == 3'h5 |-> ##[110:135] timer_out[2])
    else $error("strobe width wrong");
  cover property ($fell(timer_out[0]) && mode0_reg == 3'h2);
  cover property ($fell(timer_out[2]) && mode2_reg == 3'h5);
  cover property (io_wr && io_addr == 8'hD6 && io_wdata == 8'h40);
endmodule // tmr_timer_props

bind tmr_timer tmr_timer_props i_tmr_timer_props (.*);

// ---- testbench/tmr_host_model.sv ----
/* host cpu model: byte-wide port writes and reads
   assumes: timer samples strobes on ref_clk rising edges */
`timescale 1ns/1ps
module tmr_host_model (
  input logic ref_clk,
  output logic [7:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_wr,
  output logic io_rd,
  input logic [7:0] io_rdata
);
  // bus idle at time zero
  initial begin
    io_addr = 8'h00;
    io_wdata = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
  end
  // one-byte write, callers keep mode, low, high order
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge ref_clk);
    io_wr <= 1'b0;
  endtask
  // one-byte read, byte settled one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge ref_clk);
    io_rd <= 1'b0;
    #1;
    d = io_rdata;
  endtask
  // latched two-byte read, both bytes always taken
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    wr(8'hD6, {a[2:1], 6'h00});
    rd(a, lo);
    rd(a, hi);
    v = {hi, lo};
  endtask
endmodule // tmr_host_model

// ---- testbench/tmr_timer_test.sv ----
/* testbench: scenarios for the three-channel timer
   assumes: 125 MHz ref_clk, 1.024 MHz timer clock */
`timescale 1ns/1ps
module tmr_timer_test;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic timer_clk = 1'b0;
  logic [2:0] gate_pin = 3'h7;
  logic gate_from_ppc = 1'b0;
  logic [2:0] parallel_port_c = 3'h0;
  logic [7:0] io_addr;
  logic [7:0] io_wdata;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_rdata;
  logic [2:0] timer_out;
  int fail_count = 0;
  int num_checks = 0;
  tmr_timer i_tmr_timer (.ref_clk(ref_clk), .resetn(resetn),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_rdata(io_rdata), .timer_clk(timer_clk), .gate_pin(gate_pin),
    .gate_from_ppc(gate_from_ppc), .parallel_port_c(parallel_port_c),
    .timer_out(timer_out));
  tmr_host_model i_tmr_host_model (.ref_clk(ref_clk), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata));
  // clocks: 8 ns system, 976.5625 ns timer
  initial forever #4 ref_clk = ~ref_clk;
  initial forever #488.281 timer_clk = ~timer_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic inside_of(input int n, input int lo, input int hi);
    check({15'h0, n >= lo && n <= hi}, 16'h1);
  endtask
  // cycles until an output reaches a level, 1500 means never
  task automatic wait_out(input int c, input logic lvl, output int n);
    n = 0;
    while (timer_out[c] !== lvl && n < 1500) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_tmr_host_model.wr(a, d);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // control and unmapped ports read as FF
  task automatic test_refused;
    logic [7:0] d;
    i_tmr_host_model.rd(8'hD6, d);
    check(d, 8'hFF);
    i_tmr_host_model.rd(8'h40, d);
    check(d, 8'hFF);
  endtask
  // mode 0 interval of three ticks on counter 0
  task automatic test_mode0;
    int n;
    wr(8'hD6, 8'h30);
    wr(8'hD0, 8'h03);
    @(posedge timer_clk);
    wr(8'hD0, 8'h00);
    wait_out(0, 1'b0, n);
    wait_out(0, 1'b1, n);
    inside_of(n, 340, 400);
  endtask
  // interleaved setup, latched reads while counter 1 runs
  task automatic test_latch;
    logic [15:0] v1;
    logic [15:0] v2;
    wr(8'hD6, 8'h70);
    wr(8'hD6, 8'hB2);
    wr(8'hD4, 8'h04);
    wr(8'hD4, 8'h00);
    wr(8'hD2, 8'h34);
    wr(8'hD2, 8'h12);
    repeat (3) @(posedge timer_clk);
    i_tmr_host_model.wr(8'hD6, 8'h40);
    repeat (4) @(posedge timer_clk);
    i_tmr_host_model.rd(8'hD2, v1[7:0]);
    i_tmr_host_model.rd(8'hD2, v1[15:8]);
    i_tmr_host_model.rd16(8'hD2, v2);
    check(v1[15:8], 8'h12);
    inside_of(16'h1234 - v1, 1, 4);
    inside_of(v1 - v2, 3, 5);
  endtask
  // mode 5 on counter 2, gate from the parallel port
  task automatic test_mode5;
    int n;
    @(posedge ref_clk);
    gate_from_ppc <= 1'b1;
    wr(8'hD6, 8'hBA);
    wr(8'hD4, 8'h04);
    wr(8'hD4, 8'h00);
    wait_out(2, 1'b0, n);
    check(n, 1500);
    @(posedge ref_clk);
    parallel_port_c[2] <= 1'b1;
    wait_out(2, 1'b0, n);
    inside_of(n, 360, 750);
    wait_out(2, 1'b1, n);
    inside_of(n, 110, 135);
    @(posedge ref_clk);
    parallel_port_c[2] <= 1'b0;
    @(posedge timer_clk);
    @(posedge ref_clk);
    parallel_port_c[2] <= 1'b1;
    repeat (2) @(posedge timer_clk);
    @(posedge ref_clk);
    parallel_port_c[2] <= 1'b0;
    @(posedge timer_clk);
    @(posedge ref_clk);
    parallel_port_c[2] <= 1'b1;
    wait_out(2, 1'b0, n);
    inside_of(n, 360, 750);
    @(posedge ref_clk);
    gate_from_ppc <= 1'b0;
  endtask
  // rate generator, square wave and gate on counter 0
  task automatic test_rate_square;
    int n;
    logic [15:0] v;
    logic [15:0] w;
    wr(8'hD6, 8'h34);
    wr(8'hD0, 8'h04);
    wr(8'hD0, 8'h00);
    wait_out(0, 1'b0, n);
    wait_out(0, 1'b1, n);
    wait_out(0, 1'b0, n);
    inside_of(n, 355, 380);
    wait_out(0, 1'b1, n);
    wr(8'hD6, 8'h36);
    wr(8'hD0, 8'h04);
    wr(8'hD0, 8'h00);
    wait_out(0, 1'b0, n);
    wait_out(0, 1'b1, n);
    inside_of(n, 235, 255);
    wait_out(0, 1'b0, n);
    @(posedge ref_clk);
    gate_pin[0] <= 1'b0;
    wait_out(0, 1'b1, n);
    inside_of(n, 0, 10);
    repeat (2) @(posedge timer_clk);
    // direct reads while the low gate holds the count
    i_tmr_host_model.rd(8'hD0, v[7:0]);
    i_tmr_host_model.rd(8'hD0, v[15:8]);
    @(posedge timer_clk);
    i_tmr_host_model.rd(8'hD0, w[7:0]);
    i_tmr_host_model.rd(8'hD0, w[15:8]);
    check(w, v);
    inside_of(v, 1, 4);
    @(posedge ref_clk);
    gate_pin[0] <= 1'b1;
    wait_out(0, 1'b0, n);
    inside_of(n, 230, 400);
  endtask
  // mode 4 strobe on counter 1, started by the load
  task automatic test_mode4;
    int n;
    wr(8'hD6, 8'h78);
    wr(8'hD2, 8'h03);
    @(posedge timer_clk);
    wr(8'hD2, 8'h00);
    wait_out(1, 1'b0, n);
    inside_of(n, 340, 400);
    wait_out(1, 1'b1, n);
    inside_of(n, 110, 135);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    #400000;
    fail_count++;
    test_done;
  end
  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    test_refused;
    test_mode0;
    test_latch;
    test_mode5;
    test_rate_square;
    test_mode4;
    test_done;
  end
endmodule // tmr_timer_test
